// *** pkg/rts_pkg.sv ***
/*
 * Shared constants for the remote talk and service request block.
 * Assumes a 10 MHz system clock and a classic Wishbone register bus.
 */
package rts_pkg;
    localparam longint CLK_HZ         = 64'd10_000_000;
    localparam longint TENTH_HOUR_SEC = 64'd360;
    localparam longint TENTH_HOUR_CYC = TENTH_HOUR_SEC * CLK_HZ;

    localparam logic [7:0] ADR_CTRL   = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_ERR    = 8'h08;
    localparam logic [7:0] ADR_TALK   = 8'h0C;

    localparam logic [3:0] TALK_RST   = 4'h0;
    localparam logic [3:0] TALK_MAX   = 4'hB;
    localparam logic [4:0] ADDR_MAX   = 5'h1E;
    localparam logic [7:0] TERM_RST   = 8'h0A;
    localparam logic [7:0] MASK_RST   = 8'h00;

    localparam int         B_PROG     = 0;
    localparam int         B_RSV      = 6;
    localparam logic [7:0] RSV_BIT    = 8'h40;

    localparam int         ERR_MAX    = 80;
    localparam logic [7:0] CH_E       = 8'h45;
    localparam logic [7:0] CH_SP      = 8'h20;
    localparam logic [7:0] CH_0       = 8'h30;
    localparam logic [1:0] CLS_1      = 2'h1;
    localparam logic [1:0] CLS_2      = 2'h2;

    localparam logic [7:0]  NO_PARAM  = 8'hFF;
    localparam logic [15:0] LOCK_VAL  = 16'hD8F1;
    localparam logic [7:0]  STORED_N  = 8'h4B;
    localparam logic [15:0] ID_CODE   = 16'h5A5A; // arbitrary value
endpackage

// *** pkg/rts_err_if.sv ***
/*
 * Link between the talk logic and the error string store.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface rts_err_if;
    logic       push;
    logic [1:0] cls;
    logic [7:0] c1;
    logic [7:0] c2;
    logic       clear;
    logic [6:0] idx;
    logic [7:0] rd_byte;
    logic [6:0] len;
    modport talker (output push, cls, c1, c2, clear, idx,
                    input  rd_byte, len);
    modport store  (input  push, cls, c1, c2, clear, idx,
                    output rd_byte, len);
endinterface

// *** design/rts_err_store.sv ***
/*
 * Error string store: leading letter, blank separated entries.
 * Assumes push and clear come from logic on the same clock.
 */
`timescale 1ns/1ps
module rts_err_store
    import rts_pkg::*;
(
    input  wire logic   clk_i,   // system clock
    input  wire logic   rst_i,   // sync reset, high
    rts_err_if.store    err      // talker side
);
    typedef struct packed {
        logic [ERR_MAX-1:0][7:0] mem;
        logic [6:0]              len;
    } rts_err_state_t;

    rts_err_state_t st_ff;
    rts_err_state_t nxt_st;
    logic [6:0]     size;
    logic [3:0][7:0] ent;

    always_comb
    begin
        nxt_st = st_ff;
        size   = (err.cls == CLS_2) ? 7'h4 : 7'h3;
        ent[0] = CH_SP;
        ent[1] = CH_0 + {6'h0, err.cls};
        ent[2] = err.c1;
        ent[3] = err.c2;
        if (err.clear)
        begin
            nxt_st.len = 7'h1;
        end
        if (err.push && (nxt_st.len + size <= 7'(ERR_MAX)))
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (7'(k) < size)
                begin
                    nxt_st.mem[nxt_st.len + 7'(k)] = ent[k];
                end
            end
            nxt_st.len = nxt_st.len + size;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff     <= '0;
            st_ff.len <= 7'h1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign err.len     = st_ff.len;
    assign err.rd_byte = (err.idx == 7'h0) ? CH_E : st_ff.mem[err.idx];

    property p_len_max;
        @(posedge clk_i) disable iff (rst_i)
        err.len <= 7'(ERR_MAX);
    endproperty
    a_len_max: assert property (p_len_max)
        else $error("error string longer than limit");

    property p_first_e;
        @(posedge clk_i) disable iff (rst_i)
        (err.idx == 7'h0) |-> (err.rd_byte == CH_E);
    endproperty
    a_first_e: assert property (p_first_e)
        else $error("error string does not start with E");

    property p_cls_digit;
        @(posedge clk_i) disable iff (rst_i)
        (err.push && !err.clear && err.cls == CLS_1 && err.len < 7'h4D)
        |=> (st_ff.mem[$past(err.len) + 7'h1] == 8'h31)
            && (st_ff.mem[$past(err.len) + 7'h2] == $past(err.c1));
    endproperty
    a_cls_digit: assert property (p_cls_digit)
        else $error("class one entry encoded wrongly");
endmodule

// *** design/rts_talk_top.sv ***
/*
 * Talk response selection, reply sequencing and service request mask.
 * Assumes a classic Wishbone master on clk_i and event pulses from
 * logic on the same clock; switch inputs come from pins.
 */
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
// How it works
// - one talk selection 0..11 active; each accepted write replaces the last.
// - after reset talk selection is 0, the error list reply.
// - error reply starts with E, blank separated, newest entry last.
// - entries are class digit followed by one or two offending characters.
// - error reply never exceeds 80 characters including E and blanks.
// - completing the error reply clears the stored error string.
// - selection 1 returns poll byte; completed read clears it and SRQ.
// - selection 2 returns last parameter or a no-parameter code.
// - selection 3 returns live setup, 4 the setup captured at execute.
// - selection 6 returns tenth-hours since power-on.
// - selection 7 returns run time; held zero while switch is off.
// - selection 8 returns the stored-setting count, 75 by default.
// - selection 9 returns arb address, data and voltage.
// - selection 10 returns data then advances address; lockout gives -9999.
// - selection 11 returns data captured when ramp-to-start began.
// - mask 0..255 chooses which poll conditions raise SRQ and rsv.
// - mask bit of the rsv position itself has no effect.
// - bus address stays within 0..30, from switches or software.
// - poll byte weights 128 key,64 rsv,32 rts,16 exec,8..1 faults.
// - rsv bit follows automatically from the other condition bits.
// - terminator resets to line feed, ends every reply with EOI.
module rts_talk_top
    import rts_pkg::*;
#(
    parameter longint TENTH_CYC = TENTH_HOUR_CYC,  // cycles per 0.1 hour
    parameter logic [7:0] STORED_CNT = STORED_N    // installed settings
)
(
    input  wire logic        clk_i,                  // 10 MHz clock
    input  wire logic        rst_i,                  // sync reset, high
    input  wire logic        wb_cyc_i,               // bus cycle
    input  wire logic        wb_stb_i,               // bus strobe
    input  wire logic        wb_we_i,                // write enable
    input  wire logic [7:0]  wb_adr_i,               // byte address
    input  wire logic [3:0]  wb_sel_i,               // byte lanes
    input  wire logic [31:0] wb_dat_i,               // write data
    output logic      [31:0] wb_dat_o,               // read data
    output logic             wb_ack_o,               // acknowledge
    input  wire logic [7:0]  cond_evt_i,             // poll condition pulses
    input  wire logic        param_valid_i,          // parameter selected
    input  wire logic [7:0]  param_code_i,           // parameter code
    input  wire logic [15:0] param_val_i,            // parameter value
    input  wire logic [31:0] setup_i,                // live setup word
    input  wire logic        exec_i,                 // execute pulse
    input  wire logic [15:0] arb_addr_i,             // arb address
    input  wire logic [15:0] arb_data_i,             // arb data value
    input  wire logic [15:0] arb_volt_i,             // arb voltage
    input  wire logic        lockout_i,              // panel lockout level
    input  wire logic        rts_start_i,            // ramp-to-start begins
    input  wire logic        runtime_clear_switch_i, // run time switch pin
    input  wire logic [4:0]  addr_sw_i,              // address switch pins
    output logic             srq_o,                  // service request
    output logic [4:0]       bus_addr_o,             // bus address
    output logic             arb_addr_inc_o,         // advance arb address
    output logic             eoi_o                   // terminator byte out
);
    if (TENTH_CYC < 1 || TENTH_CYC > 64'hFFFF_FFFF)
    begin : g_bad_tenth
        $error("TENTH_CYC out of range");
    end

    localparam logic [31:0] TENTH_LAST = 32'(TENTH_CYC - 1);

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
        logic [3:0]  talk_sel;
        logic [7:0]  mask;
        logic [4:0]  addr;
        logic [7:0]  term;
        logic [7:0]  poll;
        logic        srq;
        logic [6:0]  t_idx;
        logic        eoi;
        logic        inc;
        logic        psel;
        logic [7:0]  pcode;
        logic [15:0] pval;
        logic [31:0] snap;
        logic [15:0] rts_snap;
        logic [31:0] pre_el;
        logic [15:0] elapsed;
        logic [31:0] pre_ac;
        logic [15:0] accum;
        logic [1:0]  sw_s;
        logic [4:0]  as1;
        logic [4:0]  as2;
        logic [1:0]  strap_cnt;
        logic        strap_done;
    } rts_top_state_t;

    rts_top_state_t st_ff;
    rts_top_state_t nxt_st;

    rts_err_if err_if ();

    rts_err_store u_err (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .err   (err_if.store)
    );

    // payload bytes, excluding the terminator
    function automatic logic [6:0] reply_len(input logic [3:0] sel,
                                             input logic [6:0] elen,
                                             input logic       ps);
        unique case (sel)
            4'h0:    reply_len = elen;
            4'h1:    reply_len = 7'h1;
            4'h2:    reply_len = ps ? 7'h3 : 7'h1;
            4'h3:    reply_len = 7'h4;
            4'h4:    reply_len = 7'h4;
            4'h8:    reply_len = 7'h1;
            4'h9:    reply_len = 7'h6;
            default: reply_len = 7'h2;
        endcase
    endfunction

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ref_a);
        hit = (a == ref_a);
    endfunction

    logic        req;
    logic [63:0] word;
    logic [7:0]  tbyte;
    logic [6:0]  rlen;
    logic        poll_clr;
    logic [7:0]  set_bits;
    logic [7:0]  low;
    logic        rsv;

    assign req = wb_cyc_i && wb_stb_i && !st_ff.ack;

    // reply word, left aligned, per talk selection
    always_comb
    begin
        word = 64'h0;
        unique case (st_ff.talk_sel)
            4'h1: word = {st_ff.poll, 56'h0};
            4'h2: word = st_ff.psel ? {st_ff.pcode, st_ff.pval, 40'h0}
                                    : {NO_PARAM, 56'h0};
            4'h3: word = {setup_i, 32'h0};
            4'h4: word = {st_ff.snap, 32'h0};
            4'h5: word = {ID_CODE, 48'h0};
            4'h6: word = {st_ff.elapsed, 48'h0};
            4'h7: word = {st_ff.accum, 48'h0};
            4'h8: word = {STORED_CNT, 56'h0};
            4'h9: word = {arb_addr_i, arb_data_i, arb_volt_i, 16'h0};
            4'hA: word = {lockout_i ? LOCK_VAL : arb_data_i, 48'h0};
            4'hB: word = {st_ff.rts_snap, 48'h0};
            default: word = 64'h0;
        endcase
        rlen = reply_len(st_ff.talk_sel, err_if.len, st_ff.psel);
        if (st_ff.talk_sel == TALK_RST)
        begin
            tbyte = err_if.rd_byte;
        end
        else
        begin
            tbyte = word[8 * (7 - st_ff.t_idx[2:0]) +: 8];
        end
    end

    assign err_if.idx   = st_ff.t_idx;
    assign err_if.push  = req && wb_we_i && hit(wb_adr_i, ADR_ERR);
    assign err_if.cls   = wb_dat_i[1:0];
    assign err_if.c1    = wb_dat_i[15:8];
    assign err_if.c2    = wb_dat_i[23:16];
    assign err_if.clear = req && !wb_we_i && hit(wb_adr_i, ADR_TALK)
                          && (st_ff.t_idx >= rlen)
                          && (st_ff.talk_sel == TALK_RST);

    always_comb
    begin
        nxt_st   = st_ff;
        poll_clr = 1'b0;
        nxt_st.ack = req;
        nxt_st.eoi = 1'b0;
        nxt_st.inc = 1'b0;

        nxt_st.sw_s = {st_ff.sw_s[0], runtime_clear_switch_i};
        nxt_st.as1  = addr_sw_i;
        nxt_st.as2  = st_ff.as1;
        if (!st_ff.strap_done)
        begin
            nxt_st.strap_cnt = st_ff.strap_cnt + 2'h1;
            if (st_ff.strap_cnt == 2'h2)
            begin
                nxt_st.strap_done = 1'b1;
                nxt_st.addr = (st_ff.as2 <= ADDR_MAX) ? st_ff.as2
                                                      : ADDR_MAX;
            end
        end

        if (req)
        begin
            if (wb_we_i)
            begin
                nxt_st.dat = 32'h0;
                if (hit(wb_adr_i, ADR_CTRL))
                begin
                    if (wb_sel_i[0] && wb_dat_i[3:0] <= TALK_MAX)
                    begin
                        nxt_st.talk_sel = wb_dat_i[3:0];
                        nxt_st.t_idx    = 7'h0;
                    end
                    if (wb_sel_i[1])
                    begin
                        nxt_st.mask = wb_dat_i[15:8];
                    end
                    if (wb_sel_i[2] && wb_dat_i[20:16] <= ADDR_MAX)
                    begin
                        nxt_st.addr = wb_dat_i[20:16];
                    end
                    if (wb_sel_i[3] && wb_dat_i[31:24] != 8'h00)
                    begin
                        nxt_st.term = wb_dat_i[31:24];
                    end
                end
            end
            else if (hit(wb_adr_i, ADR_CTRL))
            begin
                nxt_st.dat = {st_ff.term, 3'h0, st_ff.addr, st_ff.mask,
                              4'h0, st_ff.talk_sel};
            end
            else if (hit(wb_adr_i, ADR_STATUS))
            begin
                nxt_st.dat = {9'h0, err_if.len, 7'h0, st_ff.srq, st_ff.poll};
            end
            else if (hit(wb_adr_i, ADR_TALK))
            begin
                if (st_ff.t_idx < rlen)
                begin
                    nxt_st.dat   = {24'h0, tbyte};
                    nxt_st.t_idx = st_ff.t_idx + 7'h1;
                end
                else
                begin
                    nxt_st.dat   = {23'h0, 1'b1, st_ff.term};
                    nxt_st.eoi   = 1'b1;
                    nxt_st.t_idx = 7'h0;
                    poll_clr     = (st_ff.talk_sel == 4'h1);
                    nxt_st.inc   = (st_ff.talk_sel == 4'hA) && !lockout_i;
                end
            end
            else
            begin
                nxt_st.dat = 32'h0;
            end
        end

        // new conditions win over a clear in the same cycle
        set_bits = cond_evt_i & ~RSV_BIT;
        set_bits[B_PROG] = set_bits[B_PROG] | err_if.push;
        low = ((poll_clr ? 8'h00 : st_ff.poll) | set_bits) & ~RSV_BIT;
        rsv = |(low & nxt_st.mask & ~RSV_BIT);
        nxt_st.poll = low;
        nxt_st.poll[B_RSV] = rsv;
        nxt_st.srq = rsv;

        if (exec_i)
        begin
            nxt_st.psel = 1'b0;
            nxt_st.snap = setup_i;
        end
        else if (param_valid_i)
        begin
            nxt_st.psel  = 1'b1;
            nxt_st.pcode = param_code_i;
            nxt_st.pval  = param_val_i;
        end
        if (rts_start_i)
        begin
            nxt_st.rts_snap = arb_data_i;
        end

        if (st_ff.pre_el == TENTH_LAST)
        begin
            nxt_st.pre_el  = 32'h0;
            nxt_st.elapsed = st_ff.elapsed + 16'h1;
        end
        else
        begin
            nxt_st.pre_el = st_ff.pre_el + 32'h1;
        end

        if (!st_ff.sw_s[1])
        begin
            nxt_st.pre_ac = 32'h0;
            nxt_st.accum  = 16'h0;
        end
        else if (st_ff.pre_ac == TENTH_LAST)
        begin
            nxt_st.pre_ac = 32'h0;
            nxt_st.accum  = st_ff.accum + 16'h1;
        end
        else
        begin
            nxt_st.pre_ac = st_ff.pre_ac + 32'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff          <= '0;
            st_ff.talk_sel <= TALK_RST;
            st_ff.term     <= TERM_RST;
            st_ff.mask     <= MASK_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign wb_dat_o       = st_ff.dat;
    assign wb_ack_o       = st_ff.ack;
    assign srq_o          = st_ff.srq;
    assign bus_addr_o     = st_ff.addr;
    assign arb_addr_inc_o = st_ff.inc;
    assign eoi_o          = st_ff.eoi;

    property p_sel_range;
        @(posedge clk_i) disable iff (rst_i)
        st_ff.talk_sel <= TALK_MAX;
    endproperty
    a_sel_range: assert property (p_sel_range)
        else $error("talk selection out of range");

    property p_reset_sel;
        @(posedge clk_i)
        $fell(rst_i) |-> (st_ff.talk_sel == TALK_RST)
                         && (st_ff.term == TERM_RST);
    endproperty
    a_reset_sel: assert property (p_reset_sel)
        else $error("reset defaults wrong");

    property p_err_clear;
        @(posedge clk_i) disable iff (rst_i)
        (err_if.clear && !err_if.push) |=> (err_if.len == 7'h1);
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("error string not cleared after reply");

    property p_poll_clear;
        @(posedge clk_i) disable iff (rst_i)
        (eoi_o && $past(st_ff.talk_sel) == 4'h1 && $past(set_bits) == 8'h00)
        |-> (st_ff.poll == 8'h00) && !srq_o;
    endproperty
    a_poll_clear: assert property (p_poll_clear)
        else $error("poll byte not cleared after poll reply");

    property p_srq_mask;
        @(posedge clk_i) disable iff (rst_i)
        srq_o == ((st_ff.poll & st_ff.mask & ~RSV_BIT) != 8'h00);
    endproperty
    a_srq_mask: assert property (p_srq_mask)
        else $error("srq does not match masked conditions");

    property p_rsv_follow;
        @(posedge clk_i) disable iff (rst_i)
        st_ff.poll[B_RSV] == srq_o;
    endproperty
    a_rsv_follow: assert property (p_rsv_follow)
        else $error("rsv bit disagrees with srq");

    property p_eoi_term;
        @(posedge clk_i) disable iff (rst_i)
        eoi_o |-> wb_ack_o && (wb_dat_o[7:0] == st_ff.term)
                  ##1 !eoi_o;
    endproperty
    a_eoi_term: assert property (p_eoi_term)
        else $error("eoi without terminator byte");

    property p_addr_range;
        @(posedge clk_i) disable iff (rst_i)
        bus_addr_o <= ADDR_MAX;
    endproperty
    a_addr_range: assert property (p_addr_range)
        else $error("bus address above 30");

    property p_accum_hold;
        @(posedge clk_i) disable iff (rst_i)
        !st_ff.sw_s[1] |=> (st_ff.accum == 16'h0);
    endproperty
    a_accum_hold: assert property (p_accum_hold)
        else $error("run time not held at zero");
endmodule

// *** dv/rts_ctl_model.sv ***
/*
 * Bus controller model: one classic Wishbone cycle per bench request.
 * Assumes the bench raises req_i after a rising edge and waits for done_o.
 */
`timescale 1ns/1ps
module rts_ctl_model (
    input  wire logic        clk_i,  // system clock
    input  wire logic        rst_i,  // sync reset, high
    input  wire logic        req_i,  // start a cycle
    input  wire logic        we_i,   // write
    input  wire logic [7:0]  adr_i,  // address
    input  wire logic [31:0] dat_i,  // write data
    input  wire logic        ack_i,  // wb ack
    input  wire logic [31:0] rd_i,   // wb read data
    input  wire logic        end_i,  // end of reply flag
    output logic             done_o, // cycle finished
    output logic [31:0]      rdat_o, // read data taken
    output logic             eoi_o,  // end flag taken
    output logic             cyc_o,  // wb cyc
    output logic             stb_o,  // wb stb
    output logic             we_o,   // wb we
    output logic [7:0]       adr_o,  // wb address
    output logic [3:0]       sel_o,  // wb lanes
    output logic [31:0]      dat_o   // wb write data
);
    always_ff @(posedge clk_i)
    begin
        done_o <= cyc_o && ack_i && !rst_i;
        if (rst_i)
        begin
            cyc_o <= 1'h0;
            stb_o <= 1'h0;
            dat_o <= 32'h0;
        end
        else if (cyc_o && ack_i)
        begin
            // released data lines toggle so a stale word is never seen
            cyc_o  <= 1'h0;
            stb_o  <= 1'h0;
            dat_o  <= ~dat_o;
            rdat_o <= rd_i;
            eoi_o  <= end_i;
        end
        else if (req_i && !cyc_o && !done_o)
        begin
            // a command goes out whole in one word
            cyc_o <= 1'h1;
            stb_o <= 1'h1;
            we_o  <= we_i;
            adr_o <= adr_i;
            sel_o <= 4'hF;
            dat_o <= dat_i;
        end
    end
endmodule

// *** dv/tb.sv ***
/*
 * Self-checking bench for rts_talk_top, one task per scenario.
 * Assumes rts_ctl_model as bus master and a 10 MHz clock.
 */
`timescale 1ns/1ps
module tb;
    import rts_pkg::*;
    logic        clk_i   = 1'h0;
    logic        rst_i   = 1'h1;
    logic        req     = 1'h0;
    logic        we      = 1'h0;
    logic [7:0]  adr     = 8'h00;
    logic [31:0] wdat    = 32'h0;
    logic [7:0]  evt     = 8'h00;
    logic        pval    = 1'h0;
    logic        exec    = 1'h0;
    logic        lock    = 1'h0;
    logic        rts     = 1'h0;
    logic        rsw     = 1'h0;
    logic [31:0] setup   = 32'h12345678;
    logic [15:0] arbd    = 16'h0100;
    logic [15:0] arba    = 16'h0012;
    logic [4:0]  asw     = 5'h09;
    logic        done, cyc, stb, wwe, ack, eoi, srq, inc, tend;
    logic [7:0]  wadr;
    logic [31:0] wdo, rdo, rdat;
    logic [3:0]  sel;
    logic [4:0]  baddr;
    logic [15:0] v;
    int          n_fail  = 0;
    int          n_tests = 0;
    int          n_inc   = 0;
    int          ncyc    = 0;

    always #50 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        if (!rst_i)
            ncyc++;
        if (inc === 1'h1)
            n_inc++;
    end

    rts_ctl_model u_ctl (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
        .we_i(we), .adr_i(adr), .dat_i(wdat), .ack_i(ack), .rd_i(rdo),
        .end_i(eoi), .done_o(done), .rdat_o(rdat), .eoi_o(tend),
        .cyc_o(cyc), .stb_o(stb), .we_o(wwe), .adr_o(wadr), .sel_o(sel),
        .dat_o(wdo));
    rts_talk_top #(.TENTH_CYC(20)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(wadr),
        .wb_sel_i(sel), .wb_dat_i(wdo), .wb_dat_o(rdo), .wb_ack_o(ack),
        .cond_evt_i(evt), .param_valid_i(pval), .param_code_i(8'h46),
        .param_val_i(16'h03E8), .setup_i(setup), .exec_i(exec),
        .arb_addr_i(arba), .arb_data_i(arbd), .arb_volt_i(16'h03B5),
        .lockout_i(lock), .rts_start_i(rts), .runtime_clear_switch_i(rsw),
        .addr_sw_i(asw), .srq_o(srq), .bus_addr_o(baddr),
        .arb_addr_inc_o(inc), .eoi_o(eoi));

    task automatic print_verdict();
        $display("checks %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        req  <= 1'h1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge clk_i);
            if (done === 1'h1)
                break;
            if (i == 39)
                n_fail++;
        end
        req <= 1'h0;
    endtask

    task automatic mode(input logic [3:0] s, input logic [7:0] m);
        bus(1'h1, ADR_CTRL, {8'h0A, 3'h0, 5'h09, m, 4'h0, s});
    endtask

    task automatic rb(input logic [7:0] e);
        bus(1'h0, ADR_TALK, 32'h0);
        chk("talk byte", {23'h0, rdat[8:0]}, {24'h0, e});
    endtask

    task automatic rterm();
        bus(1'h0, ADR_TALK, 32'h0);
        chk("terminator", {23'h0, rdat[8:0]}, 32'h10A);
        chk("eoi", {31'h0, tend}, 32'h1);
    endtask

    task automatic rbs(input logic [47:0] b, input int n);
        for (int i = n - 1; i >= 0; i--)
            rb(b[i*8+:8]);
    endtask

    task automatic rq(input logic [47:0] b, input int n);
        rbs(b, n);
        rterm();
    endtask

    task automatic pulse(input logic [7:0] e);
        @(posedge clk_i);
        evt <= e;
        @(posedge clk_i);
        evt <= 8'h00;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic rv();
        bus(1'h0, ADR_TALK, 32'h0);
        v[15:8] = rdat[7:0];
        bus(1'h0, ADR_TALK, 32'h0);
        v[7:0] = rdat[7:0];
        rterm();
    endtask

    task automatic t_reset();
        repeat (4) @(posedge clk_i);
        chk("strap", {27'h0, baddr}, 32'h9);
        bus(1'h1, ADR_CTRL, 32'h0A1F000C);
        bus(1'h0, ADR_CTRL, 32'h0);
        chk("ctrl", rdat, 32'h0A090000);
        bus(1'h0, ADR_STATUS, 32'h0);
        chk("status", rdat, 32'h00010000);
        rq(48'h45, 1);
        $display("test reset done");
    endtask

    task automatic t_err();
        bus(1'h1, ADR_ERR, 32'h00004601);
        bus(1'h1, ADR_ERR, 32'h00444102);
        bus(1'h1, ADR_ERR, 32'h00005903);
        chk("srq masked", {31'h0, srq}, 32'h0);
        rbs(48'h4520_3146_2032, 6);
        rq(48'h4144_2033_59, 5);
        bus(1'h0, ADR_STATUS, 32'h0);
        chk("err len", {25'h0, rdat[22:16]}, 32'h1);
        chk("prog err", {31'h0, rdat[0]}, 32'h1);
        for (int i = 0; i < 27; i++)
            bus(1'h1, ADR_ERR, 32'h00004101);
        bus(1'h0, ADR_STATUS, 32'h0);
        chk("err full", {25'h0, rdat[22:16]}, 32'h4F);
        for (int i = 0; i < 79; i++)
            rb(i == 0 ? 8'h45 : i % 3 == 1 ? 8'h20 : i % 3 == 2 ? 8'h31 : 8'h41);
        rterm();
        $display("test error list done");
    endtask

    task automatic t_srq();
        mode(4'h1, 8'h00);
        rq(48'h01, 1);
        for (int i = 0; i < 8; i++)
        begin
            if (i == 6)
                continue;
            mode(4'h1, 8'h01 << i);
            pulse(8'h01 << i);
            chk("srq set", {31'h0, srq}, 32'h1);
            rq({40'h0, 8'h40 | (8'h01 << i)}, 1);
            chk("srq clear", {31'h0, srq}, 32'h0);
        end
        mode(4'h1, 8'h83);
        pulse(8'h82);
        rq(48'hC2, 1);
        mode(4'h1, 8'h40);
        pulse(8'h50);
        chk("rsv mask", {31'h0, srq}, 32'h0);
        rq(48'h10, 1);
        $display("test service request done");
    endtask

    task automatic t_modes();
        mode(4'h8, 8'h00);
        rq(48'h4B, 1);
        mode(4'h5, 8'h00);
        rq({32'h0, ID_CODE}, 2);
        mode(4'h2, 8'h00);
        rq(48'hFF, 1);
        @(posedge clk_i);
        pval <= 1'h1;
        @(posedge clk_i);
        pval <= 1'h0;
        rq(48'h4603E8, 3);
        @(posedge clk_i);
        exec <= 1'h1;
        @(posedge clk_i);
        exec  <= 1'h0;
        setup <= 32'hCAFEF00D;
        rq(48'hFF, 1);
        mode(4'h4, 8'h00);
        rq(48'h12345678, 4);
        mode(4'h3, 8'h00);
        rq(48'hCAFEF00D, 4);
        @(posedge clk_i);
        rts <= 1'h1;
        @(posedge clk_i);
        rts  <= 1'h0;
        arbd <= 16'h0200;
        mode(4'hB, 8'h00);
        rq(48'h0100, 2);
        mode(4'h9, 8'h00);
        rq(48'h0012020003B5, 6);
        mode(4'hA, 8'h00);
        rq(48'h0200, 2);
        chk("addr step", n_inc, 32'h1);
        lock <= 1'h1;
        rq(48'hD8F1, 2);
        chk("no step", n_inc, 32'h1);
        mode(4'h6, 8'h00);
        rv();
        chk("elapsed", {31'h0, v <= ncyc / 20 && v + 3 >= ncyc / 20}, 32'h1);
        mode(4'h7, 8'h00);
        rq(48'h0000, 2);
        rsw <= 1'h1;
        repeat (100) @(posedge clk_i);
        rv();
        chk("run time", {31'h0, v >= 3 && v <= 6}, 32'h1);
        $display("test talk modes done");
    endtask

    initial
    begin
        repeat (30000) @(posedge clk_i);
        n_fail++;
        print_verdict();
    end

    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        t_reset();
        t_err();
        t_srq();
        t_modes();
        print_verdict();
    end
endmodule
